// file: rtl/tps_params.svh
// Timing counts, register offsets and reset values of the rail sequencer
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH
`define TPS_CLK_MHZ 200
`define TPS_TICK_US 1000
`define TPS_TICK_CYCLES (`TPS_TICK_US * `TPS_CLK_MHZ)
`define TPS_STD_DELAY_MS 30
`define TPS_SETTLE_MS 120
`define TPS_REG_CTRL 12'h000
`define TPS_REG_UP 12'h004
`define TPS_REG_DOWN 12'h008
`define TPS_REG_STATUS 12'h00C
`define TPS_CTRL_ORDER_LSB 0
`define TPS_CTRL_LOCK_BIT 4
`define TPS_ORDER_RST 3'h0
`define TPS_DLY_W 8
`endif

// file: rtl/tps_pkg.sv
// Types of the rail sequencer
package tps_pkg;
    typedef enum logic [2:0] {
        TPS_OFF = 3'b000,
        TPS_UP1 = 3'b001,
        TPS_UP2 = 3'b011,
        TPS_UP3 = 3'b010,
        TPS_ON = 3'b110,
        TPS_SETTLE = 3'b111,
        TPS_DN = 3'b101
    } tps_state_t;
endpackage

// file: rtl/tps_sequencer.sv
// Three-rail power sequencer with AXI4-Lite configuration
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`include "tps_params.svh"
module tps_sequencer import tps_pkg::*; #(
    parameter int TICK_CYCLES = `TPS_TICK_CYCLES,
    parameter int DLY_W = `TPS_DLY_W
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sequencer enable
    input wire logic seq_enable,
    // Rail release open-drain pins
    input wire logic [2:0] rail_in,
    output logic rail_release_first_o,
    output logic rail_release_second_o,
    output logic rail_release_third_o,
    output logic [2:0] rail_oe,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    if (TICK_CYCLES < 2 || DLY_W < 7 || DLY_W > 10) begin : g_bad_params
        $error("tps_sequencer: bad parameters");
    end

    localparam logic [DLY_W-1:0] STD_DLY = DLY_W'(`TPS_STD_DELAY_MS);
    localparam logic [DLY_W-1:0] SETTLE = DLY_W'(`TPS_SETTLE_MS);

    // ------------------------------------------------------------
    // Configuration and sequencer state storage
    // ------------------------------------------------------------
    logic [DLY_W-1:0] up_delay [3];
    logic [DLY_W-1:0] down_delay [3];
    logic [2:0] down_order;
    logic [31:0] tick_cnt;
    logic tick;
    logic [DLY_W-1:0] dly_cnt;
    tps_state_t state;
    logic [1:0] step;
    logic [2:0] rel;
    logic en_d;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = aw_addr == `TPS_REG_CTRL;
    wire wr_up = aw_addr == `TPS_REG_UP;
    wire wr_down = aw_addr == `TPS_REG_DOWN;
    wire wr_ok = wr_ctrl || wr_up || wr_down || aw_addr == `TPS_REG_STATUS;
    wire order_ok = w_data[`TPS_CTRL_ORDER_LSB +: 3] < 3'h6;
    wire idle = state == TPS_OFF;
    wire rd_take = s_axi_arvalid && !s_axi_rvalid;
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `TPS_REG_CTRL: rd_word = {28'h000_0000, !idle, down_order};
            `TPS_REG_UP: rd_word = {8'h00, 8'(up_delay[2]), 8'(up_delay[1]), 8'(up_delay[0])};
            `TPS_REG_DOWN: rd_word = {8'h00, 8'(down_delay[2]), 8'(down_delay[1]), 8'(down_delay[0])};
            `TPS_REG_STATUS: rd_word = {16'h0000, 8'(dly_cnt), seq_enable, state, 1'b0, rel};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Configuration only changes while sequencer idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            down_order <= `TPS_ORDER_RST;
        end else if (do_write && wr_ctrl && w_strb[0] && order_ok && idle) begin
            down_order <= w_data[`TPS_CTRL_ORDER_LSB +: 3];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cfg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    up_delay[gi] <= STD_DLY;
                    down_delay[gi] <= STD_DLY;
                end else if (do_write && idle && w_strb[gi]) begin
                    if (wr_up) up_delay[gi] <= DLY_W'(w_data[8*gi +: 8]);
                    if (wr_down) down_delay[gi] <= DLY_W'(w_data[8*gi +: 8]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Shared millisecond prescaler
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || idle) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= tick_cnt == 32'(TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Down order table: rail index of steps 0 and 1, six orders
    logic [1:0] dn_rail;
    always_comb begin
        unique case ({down_order, step})
            {3'h0, 2'h0}: dn_rail = 2'h2;
            {3'h0, 2'h1}: dn_rail = 2'h1;
            {3'h1, 2'h0}: dn_rail = 2'h2;
            {3'h1, 2'h1}: dn_rail = 2'h0;
            {3'h2, 2'h0}: dn_rail = 2'h1;
            {3'h2, 2'h1}: dn_rail = 2'h2;
            {3'h3, 2'h0}: dn_rail = 2'h1;
            {3'h3, 2'h1}: dn_rail = 2'h0;
            {3'h4, 2'h0}: dn_rail = 2'h0;
            {3'h4, 2'h1}: dn_rail = 2'h2;
            {3'h5, 2'h0}: dn_rail = 2'h0;
            {3'h5, 2'h1}: dn_rail = 2'h1;
            default: dn_rail = 2'h0;
        endcase
    end
    // Last step: the rail not named in steps 0 and 1
    wire [1:0] cur_rail = (step == 2'h2) ? last_rail(down_order) : dn_rail;
    function automatic logic [1:0] last_rail(input logic [2:0] ord);
        unique case (ord)
            3'h0, 3'h2: last_rail = 2'h0;
            3'h1, 3'h4: last_rail = 2'h1;
            default: last_rail = 2'h2;
        endcase
    endfunction
    wire [DLY_W-1:0] cur_dly = (state == TPS_DN) ? down_delay[step] :
                               (state == TPS_SETTLE) ? SETTLE : up_delay[step];
    wire expired = tick && (dly_cnt + DLY_W'(1) >= cur_dly);
    wire zero_dly = cur_dly == '0;
    wire done = expired || zero_dly;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= TPS_OFF;
            step <= 2'h0;
            rel <= 3'b000;
            dly_cnt <= '0;
            en_d <= 1'b0;
        end else begin
            if (tick) dly_cnt <= dly_cnt + DLY_W'(1);
            unique case (state)
                TPS_OFF: begin
                    dly_cnt <= '0;
                    step <= 2'h0;
                    en_d <= 1'b1;
                    if (seq_enable) state <= TPS_UP1;
                end
                TPS_UP1: begin
                    if (!seq_enable) begin
                        dly_cnt <= '0;
                        state <= TPS_OFF;
                    end else if (done) begin
                        rel[0] <= 1'b1;
                        dly_cnt <= '0;
                        step <= 2'h1;
                        state <= TPS_UP2;
                    end
                end
                TPS_UP2, TPS_UP3: begin
                    // Drop stays remembered until power-down
                    if (!seq_enable) en_d <= 1'b0;
                    if (done) begin
                        rel[step] <= 1'b1;
                        dly_cnt <= '0;
                        step <= (state == TPS_UP2) ? 2'h2 : 2'h0;
                        state <= (state == TPS_UP2) ? TPS_UP3 :
                                 (!seq_enable || !en_d) ? TPS_SETTLE : TPS_ON;
                    end
                end
                TPS_SETTLE: begin
                    if (done) begin
                        dly_cnt <= '0;
                        state <= TPS_DN;
                    end
                end
                TPS_ON: begin
                    dly_cnt <= '0;
                    if (!seq_enable) state <= TPS_DN;
                end
                TPS_DN: begin
                    if (done) begin
                        rel[cur_rail] <= 1'b0;
                        dly_cnt <= '0;
                        step <= step + 2'h1;
                        if (step == 2'h2) state <= TPS_OFF;
                    end
                end
                default: state <= TPS_OFF;
            endcase
        end
    end

    // Open-drain drive: pull low while rail held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rail_oe <= 3'b111;
            rail_release_first_o <= 1'b0;
            rail_release_second_o <= 1'b0;
            rail_release_third_o <= 1'b0;
        end else begin
            rail_oe <= ~rel;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_order_up;
        @(posedge aclk) disable iff (!aresetn) $rose(rel[1]) |-> rel[0];
    endproperty
    a_order_up: assert property (p_order_up) else $error("second rail released before first");
    property p_third_last;
        @(posedge aclk) disable iff (!aresetn) $rose(rel[2]) |-> rel[1] && rel[0];
    endproperty
    a_third_last: assert property (p_third_last) else $error("third rail released early");
    property p_od;
        @(posedge aclk) disable iff (!aresetn) ##1 rail_oe == ~$past(rel);
    endproperty
    a_od: assert property (p_od) else $error("open-drain enable not inverse of release");
    property p_held_off;
        @(posedge aclk) disable iff (!aresetn) state == TPS_OFF && !$past(seq_enable) |-> rel == 3'b000 || $past(state) == TPS_DN;
    endproperty
    a_held_off: assert property (p_held_off) else $error("rail released while idle");
    property p_abort_first;
        @(posedge aclk) disable iff (!aresetn) state == TPS_UP1 && !seq_enable |=> state == TPS_OFF && dly_cnt == '0 && rel == 3'b000;
    endproperty
    a_abort_first: assert property (p_abort_first) else $error("first timer not reset on early disable");
    property p_down_stays;
        @(posedge aclk) disable iff (!aresetn) state == TPS_DN |-> !$rose(rel[0]) && !$rose(rel[1]) && !$rose(rel[2]);
    endproperty
    a_down_stays: assert property (p_down_stays) else $error("rail released during power-down");
    property p_order_legal;
        @(posedge aclk) disable iff (!aresetn) down_order < 3'h6;
    endproperty
    a_order_legal: assert property (p_order_legal) else $error("illegal down order");
    property p_tick;
        @(posedge aclk) disable iff (!aresetn) tick |=> !tick;
    endproperty
    a_tick: assert property (p_tick) else $error("prescaler tick longer than one cycle");
endmodule // tps_sequencer

// file: sim/tps_rail_load.sv
// Regulator enable inputs with pull-ups on the three rail lines
module tps_rail_load (
    // Open-drain drive from the sequencer
    input wire logic [2:0] rail_oe,
    input wire logic [2:0] rail_data,
    // Resolved line levels
    output logic [2:0] rail_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line floats up to the pull-up
    assign rail_level = (rail_oe & rail_data) | ~rail_oe;
endmodule // tps_rail_load

// file: sim/tps_sequencer_tb_top.sv
// Self-checking bench of the three-rail sequencer
`include "tps_params.svh"
module tps_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    localparam int LIMIT = 20000;
    logic aclk, aresetn, seq_enable, r_first, r_second, r_third;
    logic [2:0] rail_in, rail_oe;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    tps_sequencer #(.TICK_CYCLES(TICK)) uut (.aclk(aclk), .aresetn(aresetn), .seq_enable(seq_enable),
        .rail_in(rail_in), .rail_release_first_o(r_first), .rail_release_second_o(r_second),
        .rail_release_third_o(r_third), .rail_oe(rail_oe), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    tps_rail_load load (.rail_oe(rail_oe), .rail_data({r_third, r_second, r_first}), .rail_level(rail_in));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Idle edge keeps back-to-back calls apart
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // Idle edge keeps back-to-back calls apart
        @(posedge aclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        checked++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic chk_gaps(input string nm, input int t[3], input int d[3]);
        int p;
        p = 0;
        for (int i = 0; i < 3; i++) begin
            chk_rng(nm, d[i] * TICK - TICK - 2, d[i] * TICK + TICK + 4, t[i] - p);
            p = t[i];
        end
    endtask
    // Record which rail changes at each step and when
    task automatic steps(input logic dir, output logic [5:0] s, output int t[3]);
        logic [2:0] prev, diff;
        int n, k;
        prev = rail_oe;
        n = 0;
        k = 0;
        s = '0;
        while (k < 3 && n < 3000) begin
            @(posedge aclk);
            n++;
            diff = dir ? (rail_oe & ~prev) : (prev & ~rail_oe);
            for (int i = 0; i < 3; i++) begin
                if (diff[i] && k < 3) begin
                    s = {s[3:0], 2'(i)};
                    t[k] = n;
                    k++;
                end
            end
            prev = rail_oe;
        end
    endtask
    task automatic wait_oe(input logic [2:0] v, output int n);
        n = 0;
        while (rail_oe !== v && n < 3000) begin
            @(posedge aclk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [1:0] r;
        logic [31:0] d;
        chk("rails at reset", 32'h7, 32'(rail_oe));
        chk("levels at reset", 32'h0, 32'(rail_in));
        axi_rd(`TPS_REG_UP, d, r);
        chk("up delays", 32'h001E1E1E, 32'(d[23:0]));
        axi_rd(`TPS_REG_DOWN, d, r);
        chk("down delays", 32'h001E1E1E, 32'(d[23:0]));
        axi_rd(`TPS_REG_CTRL, d, r);
        chk("default order", 32'h0, 32'(d[2:0]));
        axi_rd(12'h010, d, r);
        chk("unmapped read", 32'h2, 32'(r));
        axi_wr(12'h010, 32'h0, r);
        chk("unmapped write", 32'h2, 32'(r));
        chk("rails still held", 32'h7, 32'(rail_oe));
        $display("test reset done");
    endtask
    task automatic t_up();
        logic [1:0] r;
        logic [5:0] s;
        int t[3];
        axi_wr(`TPS_REG_UP, 32'h00030201, r);
        axi_wr(`TPS_REG_DOWN, 32'h00030201, r);
        seq_enable <= 1'b1;
        steps(1'b0, s, t);
        chk("up order", 32'h06, 32'(s));
        chk_gaps("up gaps", t, '{1, 2, 3});
        @(posedge aclk);
        chk("released levels", 32'h7, 32'(rail_in));
        chk("drive data", 32'h0, 32'({r_third, r_second, r_first}));
        seq_enable <= 1'b0;
        steps(1'b1, s, t);
        chk("down order", 32'h24, 32'(s));
        chk_gaps("down gaps", t, '{1, 2, 3});
        $display("test up done");
    endtask
    task automatic t_orders();
        logic [5:0] tab [6] = '{6'h24, 6'h21, 6'h18, 6'h12, 6'h09, 6'h06};
        logic [1:0] r;
        logic [31:0] d;
        logic [5:0] s;
        int t[3];
        axi_wr(`TPS_REG_UP, 32'h00010101, r);
        axi_wr(`TPS_REG_DOWN, 32'h00010101, r);
        for (int o = 0; o < 6; o++) begin
            axi_wr(`TPS_REG_CTRL, 32'(o), r);
            axi_rd(`TPS_REG_CTRL, d, r);
            chk("order field", 32'(o), 32'(d[2:0]));
            seq_enable <= 1'b1;
            steps(1'b0, s, t);
            chk("fixed up order", 32'h06, 32'(s));
            seq_enable <= 1'b0;
            steps(1'b1, s, t);
            chk("selected down order", 32'(tab[o]), 32'(s));
            repeat (3) @(posedge aclk);
        end
        axi_wr(`TPS_REG_CTRL, 32'h6, r);
        axi_rd(`TPS_REG_CTRL, d, r);
        chk("bad order kept out", 32'h5, 32'(d[2:0]));
        axi_wr(`TPS_REG_CTRL, 32'h0, r);
        $display("test orders done");
    endtask
    task automatic t_abort();
        logic [1:0] r;
        logic [5:0] s;
        int t[3];
        axi_wr(`TPS_REG_UP, 32'h00010103, r);
        seq_enable <= 1'b1;
        repeat (25) @(posedge aclk);
        seq_enable <= 1'b0;
        repeat (20) @(posedge aclk);
        chk("rails after early drop", 32'h7, 32'(rail_oe));
        seq_enable <= 1'b1;
        steps(1'b0, s, t);
        chk_gaps("restarted gaps", t, '{3, 1, 1});
        seq_enable <= 1'b0;
        steps(1'b1, s, t);
        $display("test abort done");
    endtask
    task automatic t_settle();
        logic [1:0] r;
        int n;
        axi_wr(`TPS_REG_UP, 32'h00030301, r);
        seq_enable <= 1'b1;
        wait_oe(3'b110, n);
        seq_enable <= 1'b0;
        wait_oe(3'b000, n);
        chk("all released", 32'h0, 32'(rail_oe));
        wait_oe(3'b100, n);
        chk_rng("settle wait", 119 * TICK - 2, 122 * TICK + 4, n);
        wait_oe(3'b111, n);
        chk("all held again", 32'h7, 32'(rail_oe));
        $display("test settle done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        aresetn = 1'b0;
        seq_enable = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_up();
        t_orders();
        t_abort();
        t_settle();
        complete_run();
    end
endmodule // tps_sequencer_tb_top
